// [accel_irq_pkg.sv]
// package for the accelerometer interrupt status block
// assumes a single 100 MHz clock domain and a byte-wide register read port
package accel_irq_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] data_status_addr = 8'h00;
    localparam logic [7:0] x_high_addr = 8'h01;
    localparam logic [7:0] y_high_addr = 8'h03;
    localparam logic [7:0] z_high_addr = 8'h05;
    localparam logic [7:0] power_state_addr = 8'h0b;
    localparam logic [7:0] irq_origin_addr = 8'h0c;
    localparam logic [7:0] part_identity_addr = 8'h0d;
    localparam logic [7:0] orientation_state_addr = 8'h10;
    localparam logic [7:0] fall_motion_event_addr = 8'h16;
    localparam logic [7:0] transient_event_addr = 8'h1e;
    localparam logic [7:0] tap_event_addr = 8'h22;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int autosleep_pos = 7;
    localparam int transient_pos = 5;
    localparam int orientation_pos = 4;
    localparam int tap_pos = 3;
    localparam int fall_motion_pos = 2;
    localparam int sample_ready_pos = 0;
    localparam int fresh_pos = 3;
    localparam int overrun_pos = 7;
    localparam logic [7:0] byte_zero = 8'h00;
    localparam logic [15:0] count_zero = 16'h0000;
    localparam logic [15:0] count_one = 16'h0001;
    localparam logic [2:0] axes_none = 3'h0;
    localparam logic [2:0] axes_all = 3'h7;

    typedef enum logic [1:0]
    {
        mode_standby = 2'b00,
        mode_wake = 2'b01,
        mode_sleep = 2'b10
    } power_state_t;

    // event conditions from the embedded functions, all levels
    typedef struct packed
    {
        logic sample_fresh;
        logic sample_overrun;
        logic transient_active;
        logic tap_active;
        logic fall_motion_active;
        logic [1:0] portrait_landscape_state;
        logic front_back_state;
        logic tilt_lockout_bit;
    } event_in_t;

    // interrupt enables and auto sleep controls
    typedef struct packed
    {
        logic active;
        logic autosleep_en;
        logic sample_ready_en;
        logic transient_en;
        logic orientation_en;
        logic tap_en;
        logic fall_motion_en;
        logic [4:0] wake_src_en;
        logic [2:0] axis_en;
    } control_t;

endpackage

// [accel_interrupt_status.sv]
// interrupt source, power state and identity registers of the accelerometer
// assumes event levels and read strobes synchronous to clock
//
// Summary of operation
// - power state field reads 00 standby, 01 wake, 10 sleep; resets 00
// - flags set on rising condition and held until their clearing read
// - a one means the function asserted; zero means not or deasserted
// - irq origin at 0x0c: bits 7,5,4,3,2,0; bits 6,1 zero; reset 0
// - sample ready flag when overrun or fresh set and enabled
// - sample ready flag clears only on axis data read, not status read
// - combined fresh bit clears once high bytes of enabled axes are read
// - autosleep flag set on sleep/wake event; cleared by power state read
// - wake to sleep after idle timeout without interrupt; low rate
// - sleep to wake on selected wake event; high rate
// - transient flag from its event bit and enable; cleared reading it
// - orientation flag from changed bit and enable; cleared reading it
// - orientation changed bit set on front/back, portrait or lockout change
// - tap flag from tap event bit and enable; cleared reading it
// - fall/motion flag from its event bit and enable; cleared reading it
// - identity register at 0x0d is read only and fixed
module accel_interrupt_status #(
    parameter logic [7:0] part_code = 8'h5c, // arbitrary value
    parameter int count_width = 16
)(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // embedded function conditions and controls
    input wire accel_irq_pkg::event_in_t events,
    input wire accel_irq_pkg::control_t ctrl,
    input wire logic [count_width-1:0] idle_timeout_count,
    // register read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // status out
    output accel_irq_pkg::power_state_t power_state_code,
    output logic high_output_rate,
    output logic [7:0] irq_origin
);

    // the counter is cleared and incremented through 16-bit package constants
    if (count_width < 1 || count_width > 16)
    begin
        $error("count_width must be 1..16");
    end

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    logic rd_power, rd_trans, rd_orient, rd_tap, rd_fm, rd_status;
    logic [2:0] rd_axis;
    always_comb
    begin
        rd_power = rd_en && rd_addr == accel_irq_pkg::power_state_addr;
        rd_trans = rd_en && rd_addr == accel_irq_pkg::transient_event_addr;
        rd_orient = rd_en &&
            rd_addr == accel_irq_pkg::orientation_state_addr;
        rd_tap = rd_en && rd_addr == accel_irq_pkg::tap_event_addr;
        rd_fm = rd_en && rd_addr == accel_irq_pkg::fall_motion_event_addr;
        rd_status = rd_en && rd_addr == accel_irq_pkg::data_status_addr;
        rd_axis[0] = rd_en && rd_addr == accel_irq_pkg::x_high_addr;
        rd_axis[1] = rd_en && rd_addr == accel_irq_pkg::y_high_addr;
        rd_axis[2] = rd_en && rd_addr == accel_irq_pkg::z_high_addr;
    end

    // ------------------------------------------------------------
    // orientation change detection and axis read tracking
    // ------------------------------------------------------------
    logic [3:0] orient_prev_q, orient_prev_d;
    logic orient_changed_q, orient_changed_d;
    logic [2:0] axes_read_q, axes_read_d;
    logic fresh_clr;
    logic [3:0] orient_now;
    always_comb
    begin
        orient_now = {events.portrait_landscape_state,
            events.front_back_state, events.tilt_lockout_bit};
        orient_prev_d = orient_now;
        orient_changed_d = orient_changed_q;
        if (rd_orient)
            orient_changed_d = 1'b0;
        if (orient_now != orient_prev_q)
            orient_changed_d = 1'b1;
        // a read clears, a simultaneous change sets again
        axes_read_d = (axes_read_q | rd_axis) & ctrl.axis_en;
        fresh_clr = 1'b0;
        if (ctrl.axis_en != accel_irq_pkg::axes_none &&
            axes_read_d == ctrl.axis_en)
        begin
            fresh_clr = 1'b1;
            axes_read_d = accel_irq_pkg::axes_none;
        end
    end

    // ------------------------------------------------------------
    // interrupt source flags
    // ------------------------------------------------------------
    logic [7:0] cond, cond_prev_q, flags_q, flags_d, clr;
    logic aslp_event;
    always_comb
    begin
        cond = accel_irq_pkg::byte_zero;
        // the autosleep bit stays out of cond: the idle counter reads cond,
        // and the sleep event that sets this flag depends on that counter
        cond[accel_irq_pkg::transient_pos] =
            events.transient_active & ctrl.transient_en;
        cond[accel_irq_pkg::orientation_pos] =
            orient_changed_q & ctrl.orientation_en;
        cond[accel_irq_pkg::tap_pos] = events.tap_active & ctrl.tap_en;
        cond[accel_irq_pkg::fall_motion_pos] =
            events.fall_motion_active & ctrl.fall_motion_en;
        cond[accel_irq_pkg::sample_ready_pos] = ctrl.sample_ready_en &
            (events.sample_fresh | events.sample_overrun);
        clr = accel_irq_pkg::byte_zero;
        clr[accel_irq_pkg::autosleep_pos] = rd_power;
        clr[accel_irq_pkg::transient_pos] = rd_trans;
        clr[accel_irq_pkg::orientation_pos] = rd_orient;
        clr[accel_irq_pkg::tap_pos] = rd_tap;
        clr[accel_irq_pkg::fall_motion_pos] = rd_fm;
        // status read alone leaves the data flag set
        clr[accel_irq_pkg::sample_ready_pos] = fresh_clr & ~rd_status;
        // set beats clear so no rising edge is lost
        flags_d = (flags_q & ~clr) | (cond & ~cond_prev_q);
        // a mode change lasts one cycle, so the event is its own edge
        if (aslp_event && ctrl.autosleep_en)
            flags_d[accel_irq_pkg::autosleep_pos] = 1'b1;
    end

    // ------------------------------------------------------------
    // auto sleep / wake machine
    // ------------------------------------------------------------
    accel_irq_pkg::power_state_t mode_q, mode_d;
    logic [count_width-1:0] idle_q, idle_d;
    logic any_irq, wake_hit;
    always_comb
    begin
        any_irq = |(cond & ~cond_prev_q);
        wake_hit = |(ctrl.wake_src_en & {cond[accel_irq_pkg::transient_pos],
            cond[accel_irq_pkg::orientation_pos],
            cond[accel_irq_pkg::tap_pos],
            cond[accel_irq_pkg::fall_motion_pos],
            cond[accel_irq_pkg::sample_ready_pos]});
        mode_d = mode_q;
        idle_d = idle_q;
        aslp_event = 1'b0;
        case (mode_q)
            accel_irq_pkg::mode_standby:
            begin
                idle_d = count_width'(accel_irq_pkg::count_zero);
                if (ctrl.active)
                    mode_d = accel_irq_pkg::mode_wake;
            end
            accel_irq_pkg::mode_wake:
            begin
                if (!ctrl.active)
                    mode_d = accel_irq_pkg::mode_standby;
                else if (any_irq || !ctrl.autosleep_en)
                    idle_d = count_width'(accel_irq_pkg::count_zero);
                else if (idle_q > idle_timeout_count)
                begin
                    mode_d = accel_irq_pkg::mode_sleep;
                    aslp_event = 1'b1;
                end
                else
                    idle_d = idle_q + count_width'(accel_irq_pkg::count_one);
            end
            accel_irq_pkg::mode_sleep:
            begin
                idle_d = count_width'(accel_irq_pkg::count_zero);
                if (!ctrl.active)
                    mode_d = accel_irq_pkg::mode_standby;
                else if (wake_hit || !ctrl.autosleep_en)
                begin
                    mode_d = accel_irq_pkg::mode_wake;
                    aslp_event = wake_hit;
                end
            end
            default:
                mode_d = accel_irq_pkg::mode_standby;
        endcase
    end

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------
    logic [7:0] rd_data_d;
    always_comb
    begin
        rd_data_d = accel_irq_pkg::byte_zero;
        if (rd_en)
        begin
            case (rd_addr)
                accel_irq_pkg::power_state_addr:
                    rd_data_d = {6'h00, mode_q};
                accel_irq_pkg::irq_origin_addr:
                    rd_data_d = flags_q;
                accel_irq_pkg::part_identity_addr:
                    rd_data_d = part_code;
                accel_irq_pkg::orientation_state_addr:
                    rd_data_d = {orient_changed_q, events.tilt_lockout_bit,
                        3'h0, events.portrait_landscape_state,
                        events.front_back_state};
                default:
                    rd_data_d = accel_irq_pkg::byte_zero;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            orient_prev_q <= 4'h0;
            orient_changed_q <= 1'b0;
            axes_read_q <= accel_irq_pkg::axes_none;
            cond_prev_q <= accel_irq_pkg::byte_zero;
            flags_q <= accel_irq_pkg::byte_zero;
            mode_q <= accel_irq_pkg::mode_standby;
            idle_q <= '0;
            rd_data <= accel_irq_pkg::byte_zero;
            power_state_code <= accel_irq_pkg::mode_standby;
            high_output_rate <= 1'b0;
            irq_origin <= accel_irq_pkg::byte_zero;
        end
        else
        begin
            orient_prev_q <= orient_prev_d;
            orient_changed_q <= orient_changed_d;
            axes_read_q <= axes_read_d;
            cond_prev_q <= cond;
            flags_q <= flags_d;
            mode_q <= mode_d;
            idle_q <= idle_d;
            rd_data <= rd_data_d;
            power_state_code <= mode_d;
            high_output_rate <= mode_d == accel_irq_pkg::mode_wake;
            irq_origin <= flags_d;
        end
    end

endmodule

// [accel_interrupt_status_sva.sv]
// checker for the status, power state and identity outputs
// assumes one clock domain with async active-low reset; bound at foot
module accel_interrupt_status_sva #(
    parameter logic [7:0] part_code = 8'h5c,
    parameter int count_width = 16
)(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // block inputs
    input wire accel_irq_pkg::event_in_t events,
    input wire accel_irq_pkg::control_t ctrl,
    input wire logic [count_width-1:0] idle_timeout_count,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    // block outputs
    input wire logic [7:0] rd_data,
    input wire accel_irq_pkg::power_state_t power_state_code,
    input wire logic high_output_rate,
    input wire logic [7:0] irq_origin
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire logic tap_c = events.tap_active & ctrl.tap_en;
    wire logic trn_c = events.transient_active & ctrl.transient_en;
    wire logic rd_or =
        rd_en && rd_addr == accel_irq_pkg::orientation_state_addr;
    wire logic rd_st = rd_en && rd_addr == accel_irq_pkg::data_status_addr;
    property p_code; power_state_code != 2'b11; endproperty
    a_code: assert property (p_code)
        else $error("unused mode code reported");
    property p_rsv; !irq_origin[6] && !irq_origin[1]; endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved source bit set");
    property p_rate;
        high_output_rate == (power_state_code == accel_irq_pkg::mode_wake);
    endproperty
    a_rate: assert property (p_rate)
        else $error("output rate does not follow mode");
    property p_id;
        rd_en && rd_addr == accel_irq_pkg::part_identity_addr
            |=> rd_data == part_code;
    endproperty
    a_id: assert property (p_id)
        else $error("identity read wrong");
    property p_tap; $rose(tap_c) |-> ##[1:2] irq_origin[3]; endproperty
    a_tap: assert property (p_tap)
        else $error("tap flag not set");
    property p_trn;
        $rose(irq_origin[5]) |-> $past(trn_c) || $past(trn_c, 2);
    endproperty
    a_trn: assert property (p_trn)
        else $error("transient flag set without cause");
    property p_hold;
        irq_origin[4] && !rd_or && !$past(rd_or) |=> irq_origin[4];
    endproperty
    a_hold: assert property (p_hold)
        else $error("orientation flag lost without read");
    property p_stat;
        irq_origin[0] && rd_st && !$past(rd_en) |=> irq_origin[0];
    endproperty
    a_stat: assert property (p_stat)
        else $error("status read cleared ready flag");
    property p_aslp;
        $past(power_state_code) == accel_irq_pkg::mode_wake &&
            power_state_code == accel_irq_pkg::mode_sleep
            |-> ##[0:2] irq_origin[7];
    endproperty
    a_aslp: assert property (p_aslp)
        else $error("auto sleep flag missing");
endmodule

bind accel_interrupt_status accel_interrupt_status_sva #(
    .part_code(part_code), .count_width(count_width)) i_sva (
    .clock(clock), .arst_n(arst_n), .events(events), .ctrl(ctrl),
    .idle_timeout_count(idle_timeout_count), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data),
    .power_state_code(power_state_code),
    .high_output_rate(high_output_rate), .irq_origin(irq_origin));

// [host_reader.sv]
// host model: single register reads over the read port
// assumes reads are launched on the falling edge of clock
module host_reader (
    // clock
    input wire logic clock,
    // read port
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rd_en = 1'b0;
        rd_addr = 8'hff;
    end
    // idle address is the inverse of the last one so nothing stale matches
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clock);
        d = rd_data;
        rd_en = 1'b0;
        rd_addr = ~a;
    endtask
endmodule

// [test_accel_interrupt_status.sv]
// self-checking bench for the accelerometer interrupt status block
// assumes host_reader performs reads and the checker is bound
module test_accel_interrupt_status;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] id_code = 8'h3c; // arbitrary value
    localparam int pos[4] = '{5, 4, 3, 2};
    localparam logic [7:0] ev_addr[4] = '{
        accel_irq_pkg::transient_event_addr,
        accel_irq_pkg::orientation_state_addr,
        accel_irq_pkg::tap_event_addr, accel_irq_pkg::fall_motion_event_addr};
    logic clock, arst_n, rd_en, high_output_rate;
    logic [7:0] rd_addr, rd_data, irq_origin, d, exp_src;
    logic [15:0] idle_timeout_count;
    logic [31:0] seed = 32'h7a12d3a8;
    accel_irq_pkg::event_in_t events;
    accel_irq_pkg::control_t ctrl;
    accel_irq_pkg::power_state_t power_state_code;
    int bad_count, cmp_count, k, n, left;

    accel_interrupt_status #(.part_code(id_code), .count_width(16)) i_dut (
        .clock(clock), .arst_n(arst_n), .events(events), .ctrl(ctrl),
        .idle_timeout_count(idle_timeout_count), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data),
        .power_state_code(power_state_code),
        .high_output_rate(high_output_rate), .irq_origin(irq_origin));
    host_reader i_host (.clock(clock), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(int c);
        repeat (c) @(negedge clock);
    endtask
    // orientation condition is a change of the front/back state
    task automatic put(int f, logic v);
        case (f)
            0: events.transient_active = v;
            1: events.front_back_state = v;
            2: events.tap_active = v;
            default: events.fall_motion_active = v;
        endcase
    endtask
    task automatic wait_mode(accel_irq_pkg::power_state_t m);
        for (int i = 0; i < 50 && power_state_code !== m; i++)
            @(negedge clock);
        chk("mode", 8'(power_state_code), 8'(m));
        if (power_state_code !== m)
            print_verdict();
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial
    begin
        arst_n = 1'b0;
        events = '0;
        ctrl = '0;
        idle_timeout_count = 16'h0005;
        cyc(16);
        arst_n = 1'b1;
        chk("origin reset", irq_origin, 8'h00);
        chk("mode reset", 8'(power_state_code), 8'h00);
        i_host.rd_reg(accel_irq_pkg::part_identity_addr, d);
        chk("identity", d, id_code);
        i_host.rd_reg(8'h7f, d);
        chk("unmapped", d, 8'h00);
        $display("reset test done");
        for (k = 0; k < 4; k++)
            put(k, 1'b1);
        cyc(4);
        chk("masked", irq_origin, 8'h00);
        for (k = 0; k < 4; k++)
            put(k, 1'b0);
        // the masked front/back toggle left the changed bit up; read it off
        i_host.rd_reg(accel_irq_pkg::orientation_state_addr, d);
        chk("orient changed", d, 8'h80);
        ctrl.transient_en = 1'b1;
        ctrl.orientation_en = 1'b1;
        ctrl.tap_en = 1'b1;
        ctrl.fall_motion_en = 1'b1;
        cyc(4);
        for (k = 0; k < 4; k++)
        begin
            put(k, 1'b1);
            cyc(3 + xs() % 4);
            exp_src = 8'h01 << pos[k];
            chk("flag set", irq_origin, exp_src);
            i_host.rd_reg(accel_irq_pkg::irq_origin_addr, d);
            chk("source read", d, exp_src);
            i_host.rd_reg(ev_addr[(k + 1) % 4], d);
            cyc(1);
            chk("flag held", irq_origin, exp_src);
            i_host.rd_reg(ev_addr[k], d);
            cyc(1);
            chk("flag cleared", irq_origin, 8'h00);
            put(k, 1'b0);
            cyc(3);
            i_host.rd_reg(ev_addr[k], d);
            cyc(1);
        end
        $display("event flag test done");
        ctrl.sample_ready_en = 1'b1;
        for (n = 0; n < 2; n++)
        begin
            ctrl.axis_en = 3'(xs() % 7 + 1);
            left = ctrl.axis_en;
            if (n == 0)
                events.sample_fresh = 1'b1;
            else
                events.sample_overrun = 1'b1;
            cyc(3);
            events.sample_fresh = 1'b0;
            events.sample_overrun = 1'b0;
            i_host.rd_reg(accel_irq_pkg::data_status_addr, d);
            cyc(1);
            chk("ready after status", irq_origin, 8'h01);
            for (k = 0; k < 3; k++)
            begin
                i_host.rd_reg(accel_irq_pkg::x_high_addr + 8'(2 * k), d);
                left[k] = 1'b0;
                cyc(1);
                chk("ready after axis", irq_origin, {7'h00, left != 0});
            end
        end
        $display("sample ready test done");
        ctrl.autosleep_en = 1'b1;
        ctrl.active = 1'b1;
        wait_mode(accel_irq_pkg::mode_wake);
        chk("rate wake", {7'h00, high_output_rate}, 8'h01);
        wait_mode(accel_irq_pkg::mode_sleep);
        cyc(2);
        chk("sleep flag", irq_origin, 8'h80);
        i_host.rd_reg(accel_irq_pkg::power_state_addr, d);
        cyc(1);
        chk("mode read", d, 8'h02);
        chk("sleep flag read", irq_origin, 8'h00);
        ctrl.wake_src_en = 5'h04;
        events.tap_active = 1'b1;
        wait_mode(accel_irq_pkg::mode_wake);
        cyc(2);
        chk("wake flags", irq_origin, 8'h88);
        ctrl.active = 1'b0;
        wait_mode(accel_irq_pkg::mode_standby);
        chk("rate standby", {7'h00, high_output_rate}, 8'h00);
        $display("auto sleep test done");
        print_verdict();
    end
endmodule
